// file: rtl/daa_intl_ctrl_regs.vh
// register offsets, field positions and reset values of the line-interface control bank
`ifndef DAA_INTL_CTRL_REGS_VH
`define DAA_INTL_CTRL_REGS_VH
`define IDX_INTL_CTRL1 8'h40
`define IDX_INTL_CTRL2 8'h41
`define ADDR_INTL_CTRL1 10'h100
`define ADDR_INTL_CTRL2 10'h104
`define ADDR_STATUS 10'h108
`define ADDR_IRQ_STAT 10'h10c
`define ADDR_IRQ_MASK 10'h110
`define C1_TERM_HI 7
`define C1_SPEED_A 6
`define C1_TERM_LO 5
`define C1_FILTER 4
`define C1_SPEED_B 3
`define C1_QUENCH_HI 2
`define C1_QUENCH_LO 1
`define C1_RESET 8'h00
`define C2_CAL_CLR 7
`define C2_CAL_MAN 6
`define C2_CAL_AUTO_DIS 5
`define C2_RSVD 4
`define C2_OVL_EN 3
`define C2_BILL_EN 2
`define C2_RX_OVL 1
`define C2_BILL 0
`define C2_RESET 8'h00
`define C2_WMASK 8'hef
`define SPEED_FAST 2'h0
`define SPEED_3MS 2'h1
`define SPEED_26MS 2'h2
`define SPEED_UNDEF 2'h3
`define TERM_REAL600 2'h0
`define TERM_CPLX_GLOBAL 2'h1
`define TERM_CPLX_B 2'h2
`define TERM_CPLX_C 2'h3
`define IRQ_RX_OVL 0
`define IRQ_BILL 1
`define IRQ_CAL_DONE 2
`define IRQ_W 3
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// file: rtl/sync2.v
// two-stage synchroniser for one asynchronous level
`timescale 1ns/10ps
`default_nettype none
module sync2 (
	input wire aclk,
	input wire aresetn,
	input wire d,
	output reg q
);
reg meta_r;
always @(posedge aclk) begin
	if (!aresetn) begin
		meta_r <= 1'b0;
		q <= 1'b0;
	end else begin
		meta_r <= d;
		q <= meta_r;
	end
end
endmodule // sync2
`default_nettype wire

// file: rtl/daa_intl_control_regs.v
// AXI4-Lite bank for the line-interface international control registers
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "daa_intl_ctrl_regs.vh"
module daa_intl_control_regs (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [9:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [9:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// line-side event inputs (asynchronous)
	input wire rx_overload_in,
	input wire overload_in,
	input wire billing_tone_in,
	input wire calib_busy_in,
	// line-side controls
	output reg [1:0] hook_release_speed,
	output reg [1:0] ac_termination,
	output reg recursive_filter_sel,
	output reg calib_clear,
	output reg calib_manual_start,
	output reg calib_auto_disable,
	output reg billing_hold_offhook,
	output reg overload_detected,
	// interrupt
	output reg irq
);

reg [7:0] ctrl1_r;
reg [7:0] ctrl2_r;
reg [`IRQ_W-1:0] irq_stat_r;
reg [`IRQ_W-1:0] irq_mask_r;
reg cal_busy_d_r;
reg rx_ovl_d_r;
wire rx_ovl_s;
wire ovl_s;
wire bill_s;
wire cal_busy_s;

sync2 u_sync_rxovl (
	.aclk(aclk),
	.aresetn(aresetn),
	.d(rx_overload_in),
	.q(rx_ovl_s)
);
sync2 u_sync_ovl (
	.aclk(aclk),
	.aresetn(aresetn),
	.d(overload_in),
	.q(ovl_s)
);
sync2 u_sync_bill (
	.aclk(aclk),
	.aresetn(aresetn),
	.d(billing_tone_in),
	.q(bill_s)
);
sync2 u_sync_cal (
	.aclk(aclk),
	.aresetn(aresetn),
	.d(calib_busy_in),
	.q(cal_busy_s)
);

// write path: address and data may arrive in either order
reg aw_held_r;
reg w_held_r;
reg [9:0] awaddr_r;
reg [31:0] wdata_r;
reg wstrb0_r;
wire aw_take = s_axi_awvalid && s_axi_awready;
wire w_take = s_axi_wvalid && s_axi_wready;
wire have_aw = aw_held_r || aw_take;
wire have_w = w_held_r || w_take;
wire [9:0] wa = aw_held_r ? awaddr_r : s_axi_awaddr;
wire [31:0] wd = w_held_r ? wdata_r : s_axi_wdata;
wire wb0 = w_held_r ? wstrb0_r : s_axi_wstrb[0];
wire do_wr = have_aw && have_w && !s_axi_bvalid;
wire wr_hit = (wa == `ADDR_INTL_CTRL1) || (wa == `ADDR_INTL_CTRL2) ||
	(wa == `ADDR_IRQ_STAT) || (wa == `ADDR_IRQ_MASK) || (wa == `ADDR_STATUS);
wire lane_ok = do_wr && wb0;
wire wr_c1 = lane_ok && (wa == `ADDR_INTL_CTRL1);
wire wr_c2 = lane_ok && (wa == `ADDR_INTL_CTRL2);
wire wr_is = lane_ok && (wa == `ADDR_IRQ_STAT);
wire wr_im = lane_ok && (wa == `ADDR_IRQ_MASK);

always @(posedge aclk) begin
	if (!aresetn) begin
		aw_held_r <= 1'b0;
		w_held_r <= 1'b0;
		awaddr_r <= 10'h000;
		wdata_r <= 32'h0000_0000;
		wstrb0_r <= 1'b0;
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `AXI_OKAY;
	end else begin
		if (aw_take && !do_wr) begin
			aw_held_r <= 1'b1;
			awaddr_r <= s_axi_awaddr;
		end
		if (w_take && !do_wr) begin
			w_held_r <= 1'b1;
			wdata_r <= s_axi_wdata;
			wstrb0_r <= s_axi_wstrb[0];
		end
		if (do_wr) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
		// ready only while nothing of that channel is held or pending
		s_axi_awready <= !have_aw && !s_axi_bvalid && !s_axi_awready;
		s_axi_wready <= !have_w && !s_axi_bvalid && !s_axi_wready;
	end
end

// control registers and event flags
wire c2_bill_en = ctrl2_r[`C2_BILL_EN];
wire cal_done = cal_busy_d_r && !cal_busy_s;
wire rx_ovl_rise = rx_ovl_s && !rx_ovl_d_r;
wire [`IRQ_W-1:0] irq_set;
assign irq_set[`IRQ_RX_OVL] = rx_ovl_rise;
assign irq_set[`IRQ_BILL] = bill_s && c2_bill_en && !ctrl2_r[`C2_BILL];
assign irq_set[`IRQ_CAL_DONE] = cal_done;

reg [7:0] c2_nxt;
always @* begin
	c2_nxt = ctrl2_r;
	if (wr_c2)
		c2_nxt = (wd[7:0] & `C2_WMASK) | (ctrl2_r & ~`C2_WMASK);
	// the overload flag only clears by a zero write; a one write keeps its value
	if (wr_c2 && wd[`C2_RX_OVL])
		c2_nxt[`C2_RX_OVL] = ctrl2_r[`C2_RX_OVL];
	if (rx_ovl_s)
		c2_nxt[`C2_RX_OVL] = 1'b1;
	// manual start self-clears when the line side finishes calibrating
	if (cal_done && !(wr_c2 && wd[`C2_CAL_MAN]))
		c2_nxt[`C2_CAL_MAN] = 1'b0;
	c2_nxt[`C2_BILL] = bill_s && c2_nxt[`C2_BILL_EN];
	c2_nxt[`C2_RSVD] = 1'b0;
end

always @(posedge aclk) begin
	if (!aresetn) begin
		ctrl1_r <= `C1_RESET;
		ctrl2_r <= `C2_RESET;
		irq_stat_r <= {`IRQ_W{1'b0}};
		irq_mask_r <= {`IRQ_W{1'b0}};
		cal_busy_d_r <= 1'b0;
		rx_ovl_d_r <= 1'b0;
	end else begin
		cal_busy_d_r <= cal_busy_s;
		rx_ovl_d_r <= rx_ovl_s;
		if (wr_c1)
			ctrl1_r <= wd[7:0];
		ctrl2_r <= c2_nxt;
		// set wins over a write-one clear in the same cycle
		irq_stat_r <= (irq_stat_r & ~(wr_is ? wd[`IRQ_W-1:0] : {`IRQ_W{1'b0}})) | irq_set;
		if (wr_im)
			irq_mask_r <= wd[`IRQ_W-1:0];
	end
end

// decoded line-side controls, registered
reg [1:0] speed_nxt;
reg [1:0] term_nxt;
always @* begin
	if (!ctrl1_r[`C1_SPEED_A] && !ctrl1_r[`C1_SPEED_B] &&
		!ctrl1_r[`C1_QUENCH_HI] && !ctrl1_r[`C1_QUENCH_LO])
		speed_nxt = `SPEED_FAST;
	else if (!ctrl1_r[`C1_SPEED_A] && ctrl1_r[`C1_SPEED_B] &&
		!ctrl1_r[`C1_QUENCH_HI] && !ctrl1_r[`C1_QUENCH_LO])
		speed_nxt = `SPEED_3MS;
	else if (ctrl1_r[`C1_SPEED_A] && ctrl1_r[`C1_QUENCH_HI] && ctrl1_r[`C1_QUENCH_LO])
		speed_nxt = `SPEED_26MS;
	else
		speed_nxt = `SPEED_UNDEF;
	if (!ctrl1_r[`C1_TERM_HI])
		term_nxt = ctrl1_r[`C1_TERM_LO] ? `TERM_CPLX_GLOBAL : `TERM_REAL600;
	else
		term_nxt = ctrl1_r[`C1_TERM_LO] ? `TERM_CPLX_C : `TERM_CPLX_B;
end

always @(posedge aclk) begin
	if (!aresetn) begin
		hook_release_speed <= `SPEED_FAST;
		ac_termination <= `TERM_REAL600;
		recursive_filter_sel <= 1'b0;
		calib_clear <= 1'b0;
		calib_manual_start <= 1'b0;
		calib_auto_disable <= 1'b0;
		billing_hold_offhook <= 1'b0;
		overload_detected <= 1'b0;
		irq <= 1'b0;
	end else begin
		hook_release_speed <= speed_nxt;
		ac_termination <= term_nxt;
		recursive_filter_sel <= ctrl1_r[`C1_FILTER];
		calib_clear <= ctrl2_r[`C2_CAL_CLR];
		calib_manual_start <= ctrl2_r[`C2_CAL_MAN];
		calib_auto_disable <= ctrl2_r[`C2_CAL_AUTO_DIS];
		billing_hold_offhook <= c2_bill_en && bill_s;
		// enable is software's to time around off-hook; the block just gates
		overload_detected <= ctrl2_r[`C2_OVL_EN] && ovl_s;
		irq <= |(irq_stat_r & irq_mask_r);
	end
end

// read path
reg [31:0] rd_nxt;
reg rd_hit;
always @* begin
	rd_nxt = 32'h0000_0000;
	rd_hit = 1'b1;
	case (s_axi_araddr)
		`ADDR_INTL_CTRL1: rd_nxt[7:0] = ctrl1_r;
		`ADDR_INTL_CTRL2: rd_nxt[7:0] = ctrl2_r;
		`ADDR_STATUS: rd_nxt[1:0] = {cal_busy_s, overload_detected};
		`ADDR_IRQ_STAT: rd_nxt[`IRQ_W-1:0] = irq_stat_r;
		`ADDR_IRQ_MASK: rd_nxt[`IRQ_W-1:0] = irq_mask_r;
		default: rd_hit = 1'b0;
	endcase
end

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0000_0000;
		s_axi_rresp <= `AXI_OKAY;
	end else begin
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_nxt;
			s_axi_rresp <= rd_hit ? `AXI_OKAY : `AXI_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
		s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
	end
end

endmodule // daa_intl_control_regs
`default_nettype wire

// file: verif/daa_intl_control_regs_assertions.sv
// bus handshake and status-output checker for the control register bank
`timescale 1ns/10ps
`default_nettype none
module daa_regs_chk (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// bus handshakes
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// line side
	input wire overload_in,
	input wire overload_detected,
	input wire billing_tone_in,
	input wire billing_hold_offhook,
	input wire irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped early");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped early");
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready longer than one cycle");
	w_pulse_a: assert property (s_axi_wready |=> !s_axi_wready) else $error("wready longer than one cycle");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write not answered");
	ovl_quiet_a: assert property (!overload_in [*5] |-> !overload_detected) else $error("overload shown without cause");
	bill_quiet_a: assert property (!billing_tone_in [*5] |-> !billing_hold_offhook) else $error("hold without tone");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (irq);
	cover property (overload_detected);
endmodule // daa_regs_chk
bind daa_intl_control_regs daa_regs_chk i_daa_regs_chk (.*);
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the control register bank
`timescale 1ns/10ps
`default_nettype none
`include "daa_intl_ctrl_regs.vh"
module tb;
	logic aclk = '0, aresetn = '0;
	logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0;
	// always ready for answers: avoids re-driving them in one time step
	logic s_axi_bready = '1, s_axi_rready = '1;
	logic rx_overload_in = '0, overload_in = '0, billing_tone_in = '0, calib_busy_in = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, hook_release_speed, ac_termination;
	logic recursive_filter_sel, calib_clear, calib_manual_start, calib_auto_disable;
	logic billing_hold_offhook, overload_detected;
	int err_total = 0, num_checks = 0, cyc = 0;
	// ctrl1 value and expected {speed, termination, filter}
	logic [12:0] c1 [8] = '{{8'h00, 5'h00}, {8'h08, 5'h08}, {8'h46, 5'h10}, {8'h7e, 5'h13},
		{8'h02, 5'h18}, {8'h30, 5'h03}, {8'h80, 5'h04}, {8'ha0, 5'h06}};
	daa_intl_control_regs i_daa_intl_control_regs (.*);
	initial forever #20 aclk = ~aclk;
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			conclude;
		end
	end
	task chk(input string n, input [31:0] e, input [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// the slave may take address and data at different edges
	task wr(input [9:0] a, input [31:0] d, input [1:0] r = `AXI_OKAY);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= '1;
		s_axi_wvalid <= '1;
		fork
			begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= '0; end
			begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= '0; end
		join
		while (!s_axi_bvalid) @(posedge aclk);
		chk("bresp", r, s_axi_bresp);
	endtask
	task rd(input [9:0] a, input [31:0] e, input [1:0] r = `AXI_OKAY);
		s_axi_araddr <= a;
		s_axi_arvalid <= '1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= '0;
		do @(posedge aclk); while (!s_axi_rvalid);
		chk("rdata", e, s_axi_rdata);
		chk("rresp", r, s_axi_rresp);
	endtask
	task settle;
		repeat (4) @(posedge aclk);
	endtask
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= '1;
		@(posedge aclk);
		rd(`ADDR_INTL_CTRL2, 0);
		wr(`ADDR_INTL_CTRL2, 32'hff);
		rd(`ADDR_INTL_CTRL2, 32'hec);
		chk("calib", 3'h7, {calib_clear, calib_manual_start, calib_auto_disable});
		wr(`ADDR_INTL_CTRL2, 32'h00);
		settle;
		chk("calib", 3'h0, {calib_clear, calib_manual_start, calib_auto_disable});
		$display("control two test done");
		foreach (c1[i]) begin
			wr(`ADDR_INTL_CTRL1, {24'h0, c1[i][12:5]});
			settle;
			chk("ctrl1 outs", c1[i][4:0], {hook_release_speed, ac_termination, recursive_filter_sel});
		end
		$display("control one test done");
		overload_in <= '1;
		settle;
		chk("ovl", 0, overload_detected);
		wr(`ADDR_INTL_CTRL2, 32'h08);
		settle;
		chk("ovl", 1, overload_detected);
		rd(`ADDR_STATUS, 1);
		overload_in <= '0;
		settle;
		chk("ovl", 0, overload_detected);
		billing_tone_in <= '1;
		settle;
		rd(`ADDR_INTL_CTRL2, 32'h08);
		chk("hold", 0, billing_hold_offhook);
		wr(`ADDR_INTL_CTRL2, 32'h0c);
		settle;
		rd(`ADDR_INTL_CTRL2, 32'h0d);
		chk("hold", 1, billing_hold_offhook);
		billing_tone_in <= '0;
		settle;
		rd(`ADDR_INTL_CTRL2, 32'h0c);
		chk("hold", 0, billing_hold_offhook);
		$display("protect test done");
		rx_overload_in <= '1;
		settle;
		rx_overload_in <= '0;
		settle;
		rd(`ADDR_INTL_CTRL2, 32'h0e);
		chk("irq", 0, irq);
		wr(`ADDR_IRQ_MASK, 32'h01);
		settle;
		chk("irq", 1, irq);
		wr(`ADDR_INTL_CTRL2, 32'h0e);
		rd(`ADDR_INTL_CTRL2, 32'h0e);
		wr(`ADDR_INTL_CTRL2, 32'h0c);
		rd(`ADDR_INTL_CTRL2, 32'h0c);
		wr(`ADDR_IRQ_STAT, 32'h03);
		settle;
		chk("irq", 0, irq);
		rd(`ADDR_IRQ_STAT, 0);
		// manual calibration ends when the line side drops busy
		wr(`ADDR_INTL_CTRL2, 32'h4c);
		calib_busy_in <= '1;
		settle;
		chk("calib man", 1, calib_manual_start);
		rd(`ADDR_STATUS, 2);
		calib_busy_in <= '0;
		settle;
		rd(`ADDR_INTL_CTRL2, 32'h0c);
		rd(`ADDR_IRQ_STAT, 4);
		rd(10'h200, 0, `AXI_SLVERR);
		wr(10'h200, 32'hff, `AXI_SLVERR);
		$display("overload and interrupt test done");
		conclude;
	end
endmodule // tb
`default_nettype wire
